// file: rtl/lcfc_pkg.sv
/*
 Constants and carrier types of the credit flow control block.
 Assumes a 40 MHz core clock.
*/
package lcfc_pkg;
   localparam int HDR_W      = 8;
   localparam int DAT_W      = 12;
   localparam int CNT_W      = 12;
   localparam int NUM_TYPES  = 6;
   // Credit type indices: headers even, data odd
   localparam int T_PH       = 0;
   localparam int T_PD       = 1;
   localparam int T_NPH      = 2;
   localparam int T_NPD      = 3;
   localparam int T_COMPLETION_HEADER_CREDIT     = 4;
   localparam int T_COMPLETION_DATA_CREDIT     = 5;
   localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
   localparam logic [CNT_W-1:0] ATOMIC_NPD_MIN = 12'h002;
   // Timing figures in ns and cycles at 40 MHz
   localparam int CLK_NS         = 25;
   localparam int UPD_SHORT_NS   = 30000;
   localparam int UPD_LONG_NS    = 120000;
   localparam int LOSS_NS        = 200000;
   localparam int UPD_SHORT_CYC  = (UPD_SHORT_NS + CLK_NS - 1) / CLK_NS;
   localparam int UPD_LONG_CYC   = (UPD_LONG_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOSS_CYC       = (LOSS_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W          = 14;

   // Credit amounts for all six types of one packet or update
   typedef struct packed {
      logic [NUM_TYPES-1:0][CNT_W-1:0] amt;
   } lcfc_credits_t;

   // Transmit request from the transaction layer
   typedef struct packed {
      logic          valid;
      logic [2:0]    vc;
      logic          nullified;
      lcfc_credits_t need;
   } lcfc_tx_req_t;

   // Received credit init or update for one channel
   typedef struct packed {
      logic          valid;
      logic          init;
      logic [2:0]    vc;
      lcfc_credits_t value;
   } lcfc_upd_t;

   // Received transaction packet accounting event
   typedef struct packed {
      logic          valid;
      logic [2:0]    vc;
      logic          link_ok;
      logic          well_formed;
      logic          nullified;
      lcfc_credits_t used;
   } lcfc_rx_pkt_t;

   // Buffer space freed by the receive transaction layer
   typedef struct packed {
      logic          valid;
      logic [2:0]    vc;
      lcfc_credits_t freed;
   } lcfc_free_t;
endpackage

// file: rtl/lcfc_type_slice.sv
/*
 Counters and gate test for one credit type of one channel.
 Assumes all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lcfc_type_slice #(
   parameter int W = 8
) (
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic                    chan_init,
   input  wire logic [W-1:0]            adv_init,
   input  wire logic [W-1:0]            grant_init,
   input  wire logic                    upd_valid,
   input  wire logic [W-1:0]            upd_value,
   input  wire logic [W-1:0]            need,
   input  wire logic                    consume,
   input  wire logic                    rx_valid,
   input  wire logic [W-1:0]            rx_used,
   input  wire logic                    free_valid,
   input  wire logic [W-1:0]            freed,
   output logic                         gate_ok,
   output logic                         overflow,
   output logic                         infinite,
   output logic [W-1:0]                 granted,
   output logic [W-1:0]                 avail
);
   typedef struct packed {
      logic [W-1:0] limit;
      logic [W-1:0] consumed;
      logic [W-1:0] granted;
      logic [W-1:0] used;
      logic         inf;
   } lcfc_slice_st_t;

   lcfc_slice_st_t st_reg;
   lcfc_slice_st_t st_next;
   logic [W-1:0]   required;
   logic [W-1:0]   slack;
   logic [W-1:0]   rx_after;
   localparam logic [W-1:0] HALF = W'(1) << (W - 1);

   // Gate and overflow tests, wrapped at the field size
   always_comb begin
      required = st_reg.consumed + need;
      slack    = st_reg.limit - required;
      gate_ok  = st_reg.inf || (slack <= HALF);
      rx_after = st_reg.used + rx_used;
      // Overflow judged against the count this packet would reach
      overflow = ((st_reg.granted - rx_after) >= HALF)
                 && !(rx_after == st_reg.granted);
      infinite = st_reg.inf;
      granted  = st_reg.granted;
      avail    = st_reg.granted - st_reg.used;
   end

   // Counter updates
   always_comb begin
      st_next = st_reg;
      if (chan_init) begin
         st_next.limit    = adv_init;
         st_next.inf      = (adv_init == '0);
         st_next.consumed = '0;
         st_next.granted  = grant_init;
         st_next.used     = '0;
      end else begin
         if (upd_valid && !st_reg.inf && upd_value != st_reg.limit)
            st_next.limit = upd_value;
         if (consume)
            st_next.consumed = required;
         if (free_valid)
            st_next.granted = st_reg.granted + freed;
         if (rx_valid && !overflow)
            st_next.used = rx_after;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
endmodule
`default_nettype wire

// file: rtl/lcfc_top.sv
/*
 Credit flow control for one link port: per virtual channel transmit
 gating and receive accounting, update scheduling and the update loss
 timer. Assumes the transaction and link layers share clk, hold a
 transmit request until granted, and present one event per cycle.
*/
// Summary of operation
// - Limit counters: 8-bit headers, 12-bit data
// - Limit loaded at init, replaced by differing updates
// - Hold packets lacking advertised credit
// - Channels independent; no cross-channel blocking
// - Required total is consumed plus need
// - Send when limit minus required within half
// - Infinite advertised types always pass gate
// - All credit types of a packet pass together
// - Stalled packets let other types bypass
// - Credit return never implies completion
// - Nullified transmit leaves consumed unchanged
// - Granted counter starts at buffer size, advances
// - Used counter counts only valid received packets
// - Nullified receive leaves used unchanged
// - Overflow: discard, keep used of overflowing types, free, report
// - Keep operating after overflow error
// - Update after freeing from zero availability
// - Data below max payload: update each free
// - Payload setting chosen by configuration input
// - Extra updates are allowed
// - Periodic updates every 30 or 120 us
// - Update loss timer requests retraining at 200 us
// - Consumed clears at init, advances on send
// - All-zero advertisement means infinite credit
`timescale 1ns/1ps
`default_nettype none
module lcfc_top #(
   parameter int NUM_VC     = 2,
   parameter int UPD_SHORT  = lcfc_pkg::UPD_SHORT_CYC,
   parameter int UPD_LONG   = lcfc_pkg::UPD_LONG_CYC,
   parameter int LOSS_LIMIT = lcfc_pkg::LOSS_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic [NUM_VC-1:0]       chan_init,
   input  wire lcfc_pkg::lcfc_credits_t adv_init,
   input  wire lcfc_pkg::lcfc_credits_t grant_init,
   input  wire lcfc_pkg::lcfc_upd_t     upd_in,
   input  wire lcfc_pkg::lcfc_tx_req_t  tx_req,
   output logic                         tx_grant,
   output logic [NUM_VC-1:0]            vc_blocked,
   input  wire lcfc_pkg::lcfc_rx_pkt_t  rx_pkt,
   output logic                         rx_accept,
   output logic                         rx_discard,
   output logic                         overflow_err,
   input  wire lcfc_pkg::lcfc_free_t    free_in,
   input  wire logic [11:0]             max_payload_credit,
   input  wire logic                    atomic_support,
   input  wire logic                    link_active,
   input  wire logic                    long_sync,
   input  wire logic                    any_llp_rx,
   input  wire logic                    loss_any_llp,
   output logic [NUM_VC-1:0]            update_req,
   input  wire logic                    update_ack,
   output lcfc_pkg::lcfc_credits_t      update_value,
   output logic [2:0]                   update_vc,
   output logic                         retrain_req
);
   localparam int NT = lcfc_pkg::NUM_TYPES;
   localparam int CW = lcfc_pkg::CNT_W;
   localparam int TW = lcfc_pkg::TMR_W;

   // Whole module state in one record
   typedef struct packed {
      logic [NUM_VC-1:0]  pend;
      logic [TW-1:0]      per_cnt;
      logic [TW-1:0]      loss_cnt;
      logic               retrain;
      logic               ovf;
      logic [2:0]         sel_vc;
      lcfc_pkg::lcfc_credits_t sel_val;
   } lcfc_top_st_t;

   lcfc_top_st_t st_reg;
   lcfc_top_st_t st_next;

   // Per slice wiring, flattened over channel and type
   logic [NUM_VC-1:0][NT-1:0]          gate_ok;
   logic [NUM_VC-1:0][NT-1:0]          ovf_t;
   logic [NUM_VC-1:0][NT-1:0]          inf_t;
   logic [NUM_VC-1:0][NT-1:0][CW-1:0]  granted_t;
   logic [NUM_VC-1:0][NT-1:0][CW-1:0]  avail_t;
   logic [NUM_VC-1:0]                  vc_gate;
   logic [NUM_VC-1:0]                  vc_ovf;
   logic [NUM_VC-1:0]                  vc_event;
   logic [NUM_VC-1:0]                  vc_finite;
   logic                               all_inf;
   logic                               rx_ok;
   logic [TW-1:0]                      per_limit;
   logic [TW-1:0]                      loss_limit;

   // Channel number decodes, one hot
   logic [NUM_VC-1:0] tx_sel;
   logic [NUM_VC-1:0] upd_sel;
   logic [NUM_VC-1:0] rx_sel;
   logic [NUM_VC-1:0] free_sel;

   always_comb begin
      for (int v = 0; v < NUM_VC; v++) begin
         tx_sel[v]   = tx_req.valid  && (tx_req.vc  == 3'(v));
         upd_sel[v]  = upd_in.valid  && !upd_in.init
                       && (upd_in.vc == 3'(v));
         rx_sel[v]   = rx_pkt.valid  && (rx_pkt.vc  == 3'(v));
         free_sel[v] = free_in.valid && (free_in.vc == 3'(v));
      end
   end

   // Receive validity: integrity, form, and not nullified
   assign rx_ok = rx_pkt.link_ok && rx_pkt.well_formed
                  && !rx_pkt.nullified;

   // One slice per channel and credit type, none shared
   for (genvar v = 0; v < NUM_VC; v++) begin : g_vc
      for (genvar t = 0; t < NT; t++) begin : g_ty
         localparam int W = (t % 2 == 0) ? lcfc_pkg::HDR_W
                                          : lcfc_pkg::DAT_W;
         logic [W-1:0] gr;
         logic [W-1:0] av;
         lcfc_type_slice #(
            .W (W)
         ) u_slice (
            .clk        (clk),
            .arst_n     (arst_n),
            .chan_init  (chan_init[v]),
            .adv_init   (adv_init.amt[t][W-1:0]),
            .grant_init (grant_init.amt[t][W-1:0]),
            .upd_valid  (upd_sel[v]),
            .upd_value  (upd_in.value.amt[t][W-1:0]),
            .need       (tx_req.need.amt[t][W-1:0]),
            // Nullified sends pass the gate but cost nothing
            .consume    (tx_grant && tx_sel[v]
                         && !tx_req.nullified),
            .rx_valid   (rx_sel[v] && rx_ok),
            .rx_used    (rx_pkt.used.amt[t][W-1:0]),
            .free_valid (free_sel[v]),
            .freed      (free_in.freed.amt[t][W-1:0]),
            .gate_ok    (gate_ok[v][t]),
            .overflow   (ovf_t[v][t]),
            .infinite   (inf_t[v][t]),
            .granted    (gr),
            .avail      (av)
         );
         assign granted_t[v][t] = CW'(gr);
         assign avail_t[v][t]   = CW'(av);
      end
   end

   // Channel level gate, overflow and update triggers
   always_comb begin
      all_inf = 1'b1;
      for (int v = 0; v < NUM_VC; v++) begin
         vc_gate[v]   = &gate_ok[v];
         vc_ovf[v]    = |ovf_t[v];
         vc_finite[v] = ~&inf_t[v];
         all_inf      = all_inf && !vc_finite[v];
         vc_event[v]  = 1'b0;
         if (free_sel[v]) begin
            for (int t = 0; t < NT; t++) begin
               if (!inf_t[v][t] && free_in.freed.amt[t] != '0) begin
                  // Headers and nonposted data: refill after empty
                  if (t % 2 == 0 || t == lcfc_pkg::T_NPD) begin
                     if (avail_t[v][t] == '0)
                        vc_event[v] = 1'b1;
                     if (t == lcfc_pkg::T_NPD && atomic_support
                         && avail_t[v][t] < lcfc_pkg::ATOMIC_NPD_MIN)
                        vc_event[v] = 1'b1;
                  end else if (avail_t[v][t] < max_payload_credit) begin
                     vc_event[v] = 1'b1;
                  end
               end
            end
         end
      end
   end

   // Gate only looks at the requested channel; others flow freely
   assign tx_grant   = tx_req.valid && |(tx_sel & vc_gate);
   assign vc_blocked = tx_sel & ~vc_gate;

   // Receive verdict: overflow discards; only overflowing types skip counting
   assign rx_discard = rx_pkt.valid && rx_ok
                       && |(rx_sel & vc_ovf);
   assign rx_accept  = rx_pkt.valid && rx_ok && !rx_discard;

   assign per_limit  = long_sync ? TW'(UPD_LONG) : TW'(UPD_SHORT);
   assign loss_limit = TW'(LOSS_LIMIT);

   // Scheduling, periodic timer, loss timer and error flag
   always_comb begin
      st_next = st_reg;
      st_next.ovf = st_reg.ovf || rx_discard;
      // Completed update clears, a same-cycle event re-arms it
      if (update_ack)
         st_next.pend = st_reg.pend & ~(NUM_VC'(1) << st_reg.sel_vc);
      st_next.pend = st_next.pend | vc_event;
      // Periodic refresh counts cycles since the last sweep
      if (link_active) begin
         if (st_reg.per_cnt >= per_limit - TW'(1)) begin
            st_next.per_cnt = '0;
            st_next.pend = st_next.pend | vc_finite;
         end else begin
            st_next.per_cnt = st_reg.per_cnt + TW'(1);
         end
      end else begin
         st_next.per_cnt = '0;
      end
      // Loss timer, restarted by update traffic
      if (!link_active || all_inf || (upd_in.valid)
          || (loss_any_llp && any_llp_rx)) begin
         st_next.loss_cnt = '0;
         st_next.retrain  = 1'b0;
      end else if (st_reg.loss_cnt >= loss_limit - TW'(1)) begin
         st_next.loss_cnt = '0;
         st_next.retrain  = 1'b1;
      end else begin
         st_next.loss_cnt = st_reg.loss_cnt + TW'(1);
         st_next.retrain  = 1'b0;
      end
      // Latch the lowest pending channel and its granted values
      for (int v = NUM_VC - 1; v >= 0; v--) begin
         if (st_next.pend[v]) begin
            st_next.sel_vc = 3'(v);
            for (int t = 0; t < NT; t++)
               st_next.sel_val.amt[t] = inf_t[v][t] ? '0
                                        : granted_t[v][t];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // Request stays high until acknowledged
   always_comb begin
      update_req = '0;
      if (st_reg.pend != '0)
         update_req = NUM_VC'(1) << st_reg.sel_vc;
   end
   assign update_value = st_reg.sel_val;
   assign update_vc    = st_reg.sel_vc;
   assign retrain_req  = st_reg.retrain;
   assign overflow_err = st_reg.ovf;
   // Credit return says nothing about completion; no such output
endmodule
`default_nettype wire

// file: sim/lcfc_top_asserts.sv
/*
 Port checks on the credit flow control top.
 Assumes one clock domain; bound to lcfc_top below.
*/
`timescale 1ns/1ps
`default_nettype none
module lcfc_top_asserts #(
   parameter int NUM_VC     = 2,
   parameter int UPD_SHORT  = lcfc_pkg::UPD_SHORT_CYC,
   parameter int UPD_LONG   = lcfc_pkg::UPD_LONG_CYC,
   parameter int LOSS_LIMIT = lcfc_pkg::LOSS_CYC
) (
   input wire logic                    clk,
   input wire logic                    arst_n,
   input wire logic [NUM_VC-1:0]       chan_init,
   input wire lcfc_pkg::lcfc_credits_t adv_init,
   input wire lcfc_pkg::lcfc_credits_t grant_init,
   input wire lcfc_pkg::lcfc_upd_t     upd_in,
   input wire lcfc_pkg::lcfc_tx_req_t  tx_req,
   input wire logic                    tx_grant,
   input wire logic [NUM_VC-1:0]       vc_blocked,
   input wire lcfc_pkg::lcfc_rx_pkt_t  rx_pkt,
   input wire logic                    rx_accept,
   input wire logic                    rx_discard,
   input wire logic                    overflow_err,
   input wire lcfc_pkg::lcfc_free_t    free_in,
   input wire logic [11:0]             max_payload_credit,
   input wire logic                    atomic_support,
   input wire logic                    link_active,
   input wire logic                    long_sync,
   input wire logic                    any_llp_rx,
   input wire logic                    loss_any_llp,
   input wire logic [NUM_VC-1:0]       update_req,
   input wire logic                    update_ack,
   input wire lcfc_pkg::lcfc_credits_t update_value,
   input wire logic [2:0]              update_vc,
   input wire logic                    retrain_req
);
   // Single domain, so one clock and one disable for all checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_grant_has_req: assert property (tx_grant |-> tx_req.valid)
      else $error("grant without a request");
   a_blocked_cause: assert property (
      (|vc_blocked) |-> tx_req.valid && !tx_grant)
      else $error("blocked without request");
   a_grant_no_block: assert property (tx_grant |-> !(|vc_blocked))
      else $error("blocked flag while granting");
   a_verdict_excl: assert property (!(rx_accept && rx_discard))
      else $error("accept and discard together");
   a_accept_cause: assert property (
      rx_accept |-> rx_pkt.valid && rx_pkt.link_ok)
      else $error("accepted bad packet");
   a_ovf_reports: assert property (
      rx_pkt.valid && rx_discard && rx_pkt.link_ok && rx_pkt.well_formed
      && !rx_pkt.nullified |=> overflow_err)
      else $error("discard not reported");
   a_err_cause: assert property ($rose(overflow_err) |-> $past(rx_discard))
      else $error("error without discard");
   a_err_sticky: assert property (overflow_err |=> overflow_err)
      else $error("error flag dropped");
   a_retrain_pulse: assert property (retrain_req |=> !retrain_req)
      else $error("retrain too long");
   a_retrain_live: assert property (retrain_req |-> $past(link_active))
      else $error("retrain request while link idle");
   a_upd_onehot: assert property ($onehot0(update_req))
      else $error("update_req not one hot");
   a_upd_holds: assert property (
      (|update_req) && !update_ack && !(|chan_init) |=> (|update_req))
      else $error("update_req dropped early");
endmodule
bind lcfc_top lcfc_top_asserts #(
   .NUM_VC(NUM_VC), .UPD_SHORT(UPD_SHORT), .UPD_LONG(UPD_LONG),
   .LOSS_LIMIT(LOSS_LIMIT)
) lcfc_top_asserts_inst (.*);
`default_nettype wire

// file: sim/lcfc_peer_model.sv
/*
 Peer port model: sends updates on call, acks update requests.
 Assumes the bench calls send_update from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module lcfc_peer_model #(
   parameter int NUM_VC    = 2,
   parameter int ACK_DELAY = 2
) (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic [NUM_VC-1:0]   update_req,
   output var  logic                update_ack,
   output var  lcfc_pkg::lcfc_upd_t upd_in
);
   // Quiet at start
   initial begin
      upd_in = '0;
      update_ack = 1'b0;
   end

   // One update per call; idle value inverted
   task automatic send_update(input logic [2:0] vc,
                              input lcfc_pkg::lcfc_credits_t v);
      @(posedge clk);
      #1;
      upd_in.valid = 1'b1;
      upd_in.init = 1'b0;
      upd_in.vc = vc;
      upd_in.value = v;
      @(posedge clk);
      #1;
      upd_in.valid = 1'b0;
      upd_in.value = ~v;
   endtask

   // Ack says only that the update left; nothing about completion
   always begin
      @(posedge clk);
      #1;
      if (arst_n && (|update_req)) begin
         repeat (ACK_DELAY) @(posedge clk);
         #1;
         update_ack = 1'b1;
         @(posedge clk);
         #1;
         update_ack = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: sim/lcfc_top_tb.sv
/*
 Self-checking bench for lcfc_top.
 Assumes shortened timer parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module lcfc_top_tb;
   localparam int NV = 2;
   localparam int SHORT = 20;
   localparam int LONG = 40;
   localparam int LOSS = 60;
   logic                    clk, arst_n, tx_grant, rx_accept, rx_discard;
   logic                    overflow_err, update_ack, retrain_req;
   logic                    link_active, long_sync;
   logic                    atomic_support, any_llp_rx, loss_any_llp;
   logic [NV-1:0]           chan_init, vc_blocked, update_req;
   logic [11:0]             max_payload_credit;
   logic [2:0]              update_vc;
   lcfc_pkg::lcfc_credits_t adv_init, grant_init, update_value, lim0;
   lcfc_pkg::lcfc_upd_t     upd_in;
   lcfc_pkg::lcfc_tx_req_t  tx_req;
   lcfc_pkg::lcfc_rx_pkt_t  rx_pkt;
   lcfc_pkg::lcfc_free_t    free_in;
   int                      miscompares, n_checks;

   lcfc_top #(.NUM_VC(NV), .UPD_SHORT(SHORT), .UPD_LONG(LONG),
      .LOSS_LIMIT(LOSS)) lcfc_top_inst (.*);
   lcfc_peer_model #(.NUM_VC(NV)) lcfc_peer_model_inst (.*);

   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic lcfc_pkg::lcfc_credits_t cr(input logic [11:0] ph,
      pd, nonposted_header_credit, nonposted_data_credit, ch, cd);
      return {cd, ch, nonposted_data_credit, nonposted_header_credit, pd, ph};
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Channel init pulse; request valid is left to the caller
   task automatic init_vc(input int vc, input lcfc_pkg::lcfc_credits_t a,
                          input lcfc_pkg::lcfc_credits_t g);
      adv_init = a;
      grant_init = g;
      chan_init = NV'(1 << vc);
      tick(1);
      chan_init = '0;
   endtask
   // Request held after a grant for back to back use
   task automatic tx(input logic [2:0] vc, input logic nul,
                     input logic [11:0] ph, pd, input logic exp);
      tx_req.valid = 1'b1;
      tx_req.vc = vc;
      tx_req.nullified = nul;
      tx_req.need = cr(ph, pd, 12'h000, 12'h000, 12'h000, 12'h000);
      #5;
      chk("tx_grant", 12'(exp), 12'(tx_grant));
      chk("vc_blocked", exp ? 12'h000 : 12'(1 << vc), 12'(vc_blocked));
      if (exp)
         tick(1);
   endtask
   task automatic wait_grant;
      repeat (4) begin
         if (tx_grant === 1'b1)
            break;
         tick(1);
         #5;
      end
      chk("tx_grant late", 12'h001, 12'(tx_grant));
      tick(1);
      tx_req.valid = 1'b0;
   endtask
   task automatic rx(input logic [11:0] ph, pd, input logic ok, nul,
                     input logic acc, dis);
      rx_pkt.valid = 1'b1;
      rx_pkt.vc = 3'h0;
      rx_pkt.link_ok = ok;
      rx_pkt.well_formed = 1'b1;
      rx_pkt.nullified = nul;
      rx_pkt.used = cr(ph, pd, 12'h000, 12'h000, 12'h000, 12'h000);
      #5;
      if (!nul)
         chk("rx_accept", 12'(acc), 12'(rx_accept));
      if (ok && !nul)
         chk("rx_discard", 12'(dis), 12'(rx_discard));
      tick(1);
   endtask
   task automatic free(input logic [11:0] ph, pd);
      free_in.valid = 1'b1;
      free_in.vc = 3'h0;
      free_in.freed = cr(ph, pd, 12'h000, 12'h000, 12'h000, 12'h000);
      tick(1);
      free_in.valid = 1'b0;
   endtask
   task automatic upd_check(input logic exp, input logic [11:0] ph, pd);
      int i;
      i = 0;
      while (i < 3 && !(|update_req)) begin
         tick(1);
         i++;
      end
      chk("update_req", 12'(exp), 12'(|update_req));
      if (exp) begin
         tick(1); // Value refreshes a cycle after the request rises
         chk("update_vc", 12'h000, 12'(update_vc));
         chk("update_ph", ph, 12'(update_value.amt[lcfc_pkg::T_PH][7:0]));
         chk("update_pd", pd, update_value.amt[lcfc_pkg::T_PD]);
      end
      i = 0;
      while (i < 8 && (|update_req)) begin
         tick(1);
         i++;
      end
      chk("update_cleared", 12'h000, 12'(update_req));
   endtask

   // Transmit gate: nullified, exact boundary, refusal, update, infinite
   task automatic t_gate;
      init_vc(0, lim0, cr(12'h010, 12'h040, 12'h010, 12'h010, 12'h010,
                          12'h040));
      tx(3'h0, 1'b1, 12'h001, 12'h004, 1'b1);
      tx(3'h0, 1'b0, 12'h001, 12'h004, 1'b1);
      tx(3'h0, 1'b0, 12'h001, 12'h004, 1'b1);
      tx(3'h0, 1'b0, 12'h000, 12'h001, 1'b0);
      tick(2);
      #5;
      chk("tx_grant held", 12'h000, 12'(tx_grant));
      lcfc_peer_model_inst.send_update(3'h0, cr(12'h002, 12'h009, 12'h001,
                                       12'h001, 12'h000, 12'h000));
      wait_grant;
      init_vc(1, cr(12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000),
              cr(12'h008, 12'h040, 12'h008, 12'h008, 12'h008, 12'h040));
      tx(3'h1, 1'b0, 12'h0C8, 12'hFFF, 1'b1);
      tx(3'h1, 1'b0, 12'h0C8, 12'hFFF, 1'b1);
      tx(3'h0, 1'b0, 12'h001, 12'h000, 1'b0);
      lcfc_peer_model_inst.send_update(3'h0, cr(12'h003, 12'h009, 12'h001,
                                       12'h001, 12'h000, 12'h000));
      wait_grant;
      $display("test gate done");
   endtask

   // Receive accounting, overflow and event driven updates
   task automatic t_rx;
      init_vc(0, lim0, cr(12'h002, 12'h008, 12'h004, 12'h004, 12'h004,
                          12'h010));
      tick(10);
      rx(12'h001, 12'h004, 1'b0, 1'b0, 1'b0, 1'b0);
      rx(12'h001, 12'h004, 1'b1, 1'b0, 1'b1, 1'b0);
      rx(12'h001, 12'h004, 1'b1, 1'b1, 1'b0, 1'b0);
      rx(12'h001, 12'h004, 1'b1, 1'b0, 1'b1, 1'b0);
      rx(12'h001, 12'h004, 1'b1, 1'b0, 1'b0, 1'b1);
      rx_pkt.valid = 1'b0;
      chk("overflow_err", 12'h001, 12'(overflow_err));
      free(12'h001, 12'h004);
      upd_check(1'b1, 12'h003, 12'h00C);
      rx(12'h001, 12'h004, 1'b1, 1'b0, 1'b1, 1'b0);
      rx_pkt.valid = 1'b0;
      max_payload_credit = 12'h040;
      free(12'h000, 12'h001);
      upd_check(1'b1, 12'h003, 12'h00D);
      max_payload_credit = 12'h000;
      free(12'h000, 12'h001);
      upd_check(1'b0, 12'h000, 12'h000);
      $display("test rx done");
   endtask

   // Periodic updates in both modes, then the update loss timer
   task automatic t_timers;
      int i, j, lim;
      logic seen;
      link_active = 1'b1;
      for (j = 0; j < 4; j++) begin
         long_sync = j[1];
         lim = (j[1] ? LONG : SHORT) * 3 / 2 + 4;
         i = 0;
         while (i < 10 && (|update_req)) begin
            tick(1);
            i++;
         end
         i = 0;
         while (i < lim && !(|update_req)) begin
            tick(1);
            i++;
         end
         if (j[0])
            chk("update_period", 12'h001, 12'(|update_req));
      end
      lcfc_peer_model_inst.send_update(3'h0, lim0);
      link_active = 1'b0;
      seen = 1'b0;
      repeat (100) begin
         tick(1);
         if (retrain_req === 1'b1)
            seen = 1'b1;
      end
      chk("retrain_idle", 12'h000, 12'(seen));
      link_active = 1'b1;
      repeat (3) begin
         repeat (40) begin
            tick(1);
            if (retrain_req === 1'b1)
               seen = 1'b1;
         end
         lcfc_peer_model_inst.send_update(3'h0, lim0);
      end
      chk("retrain_restart", 12'h000, 12'(seen));
      i = 0;
      while (i < LOSS * 3 / 2 + 4 && retrain_req !== 1'b1) begin
         tick(1);
         i++;
      end
      chk("retrain_req", 12'h001, 12'(retrain_req));
      $display("test timers done");
   endtask

   // Main sequence
   initial begin
      miscompares = 0;
      n_checks = 0;
      arst_n = 1'b0;
      chan_init = '0;
      lim0 = cr(12'h002, 12'h008, 12'h001, 12'h001, 12'h000, 12'h000);
      adv_init = '0;
      grant_init = '0;
      tx_req = '0;
      rx_pkt = '0;
      free_in = '0;
      max_payload_credit = 12'h040;
      link_active = 1'b0;
      long_sync = 1'b0;
      atomic_support = 1'b0;
      any_llp_rx = 1'b0;
      loss_any_llp = 1'b0;
      tick(16);
      arst_n = 1'b1;
      t_gate;
      t_rx;
      t_timers;
      print_verdict;
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
endmodule
`default_nettype wire
